// *** irq_peer_model.sv ***
`timescale 1ns/1ps
// ------------------------------------------------------------
// Request sources and core events
// ------------------------------------------------------------
module irq_peer_model
  import irq_pkg::*;
(
  input wire logic sys_clk_i,
  output logic [irq_pkg::NUM_IRQ-1:0] irq_line_o,
  output logic nmi_line_o,
  output logic enter_o,
  output logic [irq_pkg::ID_W-1:0] enter_id_o,
  output logic return_o,
  output logic [irq_pkg::ID_W-1:0] return_id_o
);
  // Idle: all lines low, no core event
  initial begin
    irq_line_o = '0;
    nmi_line_o = 1'b0;
    enter_o = 1'b0;
    enter_id_o = '0;
    return_o = 1'b0;
    return_id_o = '0;
  end

  // Level source holds its line until told otherwise; id 31 is the NMI pin
  task automatic level_set(input int n, input logic v);
    @(posedge sys_clk_i);
    if (n == 31) begin
      nmi_line_o <= v;
    end else begin
      irq_line_o[n] <= v;
    end
  endtask

  // Three clocks high, since the input filter may drop shorter pulses
  task automatic pulse(input int n);
    level_set(n, 1'b1);
    repeat (2) @(posedge sys_clk_i);
    level_set(n, 0);
  endtask

  // Core stacks by itself; only entry or return is shown, one cycle
  task automatic core_event(input logic is_ret, input int id);
    @(posedge sys_clk_i);
    enter_o <= !is_ret;
    enter_id_o <= id[4:0];
    return_o <= is_ret;
    return_id_o <= id[4:0];
    @(posedge sys_clk_i);
    enter_o <= 1'b0;
    return_o <= 1'b0;
  endtask
endmodule // irq_peer_model

// *** irq_pkg.sv ***
package irq_pkg;
  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_IRQ = 21;
  localparam int PRIO_W = 3;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int ID_W = 5;

  // ----------------------------------------------------------------
  // Register offsets (low 16 bits of the two windows)
  // ----------------------------------------------------------------
  localparam logic [15:0] OFF_EN_SET = 16'hE100;
  localparam logic [15:0] OFF_EN_CLR = 16'hE180;
  localparam logic [15:0] OFF_PEND_SET = 16'hE200;
  localparam logic [15:0] OFF_PEND_CLR = 16'hE280;
  localparam logic [15:0] OFF_ACTIVE = 16'hE300;
  localparam logic [15:0] OFF_PRIO_BASE = 16'hE400;
  localparam logic [15:0] OFF_PRIO_LAST = 16'hE450;
  localparam logic [15:0] OFF_TYPE = 16'hE4E0;
  localparam logic [15:0] OFF_GROUP = 16'hE4E4;
  localparam logic [15:0] OFF_PRESENT = 16'hE4E8;
  localparam logic [15:0] OFF_SW_TRIG = 16'hEF00;

  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam int PRIO_FIELD_LSB = 5;
  localparam int PRIO_FIELD_STRIDE = 8;
  localparam int GROUP_LSB = 0;
  localparam logic [1:0] GROUP_RST = 2'h0;
  localparam logic [31:0] TYPE_RST = 32'h0000_0000;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [PRIO_W-1:0] PRIO_RST = 3'h0;
endpackage

// *** nested_vector_irq_ctrl.sv ***
`timescale 1ns/1ps
// How it works
// - Twenty-one peripheral inputs, each with a three-bit priority 0 to 7.
// - Lower priority number wins; level 0 is most urgent.
// - Priority splits into group and subpriority by a software-set split point.
// - Priorities may be rewritten anytime; the next arbitration uses them.
// - One non-maskable input, presented on its own output nmi_pend_o, beside the maskable request.
// - Core stacks state itself; block only tracks entry and return events.
// - Pulse lines sampled on rising clock edge and latched.
// - Line high while not active makes a level interrupt pending.
// - Rising edge on the line makes a pulse interrupt pending.
// - Software set-pending or trigger register write makes it pending.
// - Service entry clears pending and sets active.
// - Level return: line high gives pending, else inactive.
// - Pulse during service gives pending and active; stays pending after return.
// - No pulse during service: return leaves it inactive.
// - Level clear-pending ignored while line high, else inactive.
// - Pulse clear-pending drops only pending, keeps active.
// - Registers decode in two windows, main and trigger.
module nested_vector_irq_ctrl #(
  parameter int N = irq_pkg::NUM_IRQ
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic [irq_pkg::NUM_IRQ-1:0] irq_line_i,
  input wire logic nmi_line_i,
  input wire logic enter_i,
  input wire logic [irq_pkg::ID_W-1:0] enter_id_i,
  input wire logic return_i,
  input wire logic [irq_pkg::ID_W-1:0] return_id_i,
  input wire logic [irq_pkg::ADDR_W-1:0] addr_i,
  input wire logic [irq_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [irq_pkg::DATA_W-1:0] rdata_o,
  output logic req_valid_o,
  output logic [irq_pkg::ID_W-1:0] req_id_o,
  output logic [irq_pkg::PRIO_W-1:0] req_group_o,
  output logic [irq_pkg::PRIO_W-1:0] req_sub_o,
  output logic nmi_pend_o
);
  import irq_pkg::*;

  initial begin
    if (N != NUM_IRQ) $error("interrupt count must match package");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [N-1:0] s1_r, s2_r, s3_r, line_r;
  logic n1_r, n2_r, n3_r, nmi_lvl_r, nmi_old_r;
  logic [N-1:0] pend_r, pend_nxt, act_r, act_nxt, en_r, type_r;
  logic [1:0] group_r;
  logic [N-1:0] rise, w_set, w_clr, enter_v, ret_v;
  logic [N-1:0] s_prev_r;
  logic prio_wr;
  logic [4:0] prio_idx;
  logic [PRIO_W-1:0] prio_rd;
  logic [N*PRIO_W-1:0] prio_all;
  logic rd_prio_r;
  logic [DATA_W-1:0] rdata_nxt, rdata_r;
  logic best_v;
  logic [ID_W-1:0] best_id;
  logic [PRIO_W-1:0] best_p;

  function automatic logic [N-1:0] onehot(input logic [ID_W-1:0] id);
    onehot = '0;
    if (int'(id) < N) onehot[id] = 1'b1;
  endfunction

  // ----------------------------------------------------------------
  // Input synchronisers, three stages; change once stages 2 and 3 agree
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      line_r <= '0;
      n1_r <= 1'b0;
      n2_r <= 1'b0;
      n3_r <= 1'b0;
      nmi_lvl_r <= 1'b0;
    end else begin
      s1_r <= irq_line_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      line_r <= (s2_r & s3_r) | (line_r & (s2_r | s3_r));
      n1_r <= nmi_line_i;
      n2_r <= n1_r;
      n3_r <= n2_r;
      nmi_lvl_r <= (n2_r & n3_r) | (nmi_lvl_r & (n2_r | n3_r));
    end
  end

  // Rising edge of the filtered line; a pulse of one clock can be missed by
  // the filter, the price of glitch immunity on asynchronous pins
  assign rise = line_r & ~s_prev_r;
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) s_prev_r <= '0;
    else s_prev_r <= line_r;
  end

  // ----------------------------------------------------------------
  // Register strobes
  // ----------------------------------------------------------------
  always_comb begin
    w_set = '0;
    w_clr = '0;
    prio_wr = 1'b0;
    prio_idx = '0;
    if (wr_i && addr_i == OFF_PEND_SET) begin
      w_set = wdata_i[N-1:0];
    end else if (wr_i && addr_i == OFF_PEND_CLR) begin
      w_clr = wdata_i[N-1:0];
    end else if (wr_i && addr_i == OFF_SW_TRIG) begin
      w_set = onehot(wdata_i[ID_W-1:0]);
    end
    if (addr_i >= OFF_PRIO_BASE && addr_i <= OFF_PRIO_LAST) begin
      prio_idx = 5'((addr_i - OFF_PRIO_BASE) >> 2);
      prio_wr = wr_i;
    end
  end

  assign enter_v = enter_i ? onehot(enter_id_i) : '0;
  assign ret_v = return_i ? onehot(return_id_i) : '0;

  // ----------------------------------------------------------------
  // Pending / active state per interrupt
  // ----------------------------------------------------------------
  always_comb begin
    pend_nxt = pend_r;
    act_nxt = act_r;
    for (int i = 0; i < N; i++) begin
      if (type_r[i]) begin
        // Pulse mode
        if (w_clr[i]) pend_nxt[i] = 1'b0;
        if (enter_v[i]) begin
          pend_nxt[i] = 1'b0;
          act_nxt[i] = 1'b1;
        end
        if (ret_v[i]) act_nxt[i] = 1'b0;
        // Set beats clear and entry, so a recurring pulse survives
        if (rise[i] || w_set[i]) pend_nxt[i] = 1'b1;
      end else begin
        // Level mode
        if (w_clr[i] && !line_r[i]) pend_nxt[i] = 1'b0;
        if (enter_v[i]) begin
          pend_nxt[i] = 1'b0;
          act_nxt[i] = 1'b1;
        end
        if (ret_v[i]) begin
          act_nxt[i] = 1'b0;
          pend_nxt[i] = line_r[i];
        end
        if (line_r[i] && !act_r[i] && !enter_v[i]) pend_nxt[i] = 1'b1;
        if (w_set[i]) pend_nxt[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      pend_r <= '0;
      act_r <= '0;
    end else begin
      pend_r <= pend_nxt;
      act_r <= act_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Control registers: enable, type, group split
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      en_r <= '0;
      type_r <= TYPE_RST[N-1:0];
      group_r <= GROUP_RST;
    end else if (wr_i) begin
      if (addr_i == OFF_EN_SET) en_r <= en_r | wdata_i[N-1:0];
      else if (addr_i == OFF_EN_CLR) en_r <= en_r & ~wdata_i[N-1:0];
      else if (addr_i == OFF_TYPE) type_r <= wdata_i[N-1:0];
      else if (addr_i == OFF_GROUP) group_r <= wdata_i[GROUP_LSB +: 2];
    end
  end

  // ----------------------------------------------------------------
  // Priority storage, live rewrite allowed
  // ----------------------------------------------------------------
  prio_table #(.DEPTH(N), .WIDTH(PRIO_W)) u_prio (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .wr_en_i(prio_wr),
    .wr_idx_i(prio_idx),
    .wr_data_i(wdata_i[PRIO_FIELD_LSB +: PRIO_W]),
    .rd_idx_i(prio_idx),
    .rd_data_o(prio_rd),
    .all_o(prio_all)
  );

  // ----------------------------------------------------------------
  // Read mux; data stand in the cycle after the strobe
  // ----------------------------------------------------------------
  always_comb begin
    rdata_nxt = ZERO_WORD;
    if (addr_i == OFF_EN_SET || addr_i == OFF_EN_CLR) begin
      rdata_nxt[N-1:0] = en_r;
    end else if (addr_i == OFF_PEND_SET || addr_i == OFF_PEND_CLR) begin
      rdata_nxt[N-1:0] = pend_r;
    end else if (addr_i == OFF_ACTIVE) begin
      rdata_nxt[N-1:0] = act_r;
    end else if (addr_i == OFF_TYPE) begin
      rdata_nxt[N-1:0] = type_r;
    end else if (addr_i == OFF_GROUP) begin
      rdata_nxt[1:0] = group_r;
    end else if (addr_i == OFF_PRESENT) begin
      rdata_nxt[N-1:0] = line_r;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      rd_prio_r <= 1'b0;
      rdata_r <= ZERO_WORD;
    end else begin
      rd_prio_r <= rd_i && addr_i >= OFF_PRIO_BASE && addr_i <= OFF_PRIO_LAST;
      rdata_r <= rd_i ? rdata_nxt : ZERO_WORD;
    end
  end
  // Priority word comes from the table's read register, so both arms are flops
  assign rdata_o = rd_prio_r ? (DATA_W'(prio_rd) << PRIO_FIELD_LSB) : rdata_r;

  // ----------------------------------------------------------------
  // Arbiter: strict less-than keeps the lower number on ties
  // ----------------------------------------------------------------
  always_comb begin
    best_v = 1'b0;
    best_id = '0;
    best_p = '1;
    for (int i = 0; i < N; i++) begin
      if (pend_r[i] && en_r[i] && !act_r[i]) begin
        if (!best_v || prio_all[i*PRIO_W +: PRIO_W] < best_p) begin
          best_v = 1'b1;
          best_id = ID_W'(i);
          best_p = prio_all[i*PRIO_W +: PRIO_W];
        end
      end
    end
  end

  // Registered request toward the core; group and sub split by group_r
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      req_valid_o <= 1'b0;
      req_id_o <= '0;
      req_group_o <= '0;
      req_sub_o <= '0;
    end else begin
      req_valid_o <= best_v;
      req_id_o <= best_id;
      req_group_o <= best_p >> group_r;
      req_sub_o <= best_p & ((PRIO_W'(1) << group_r) - PRIO_W'(1));
    end
  end

  // NMI latch: edge sets, core entry with id 31 clears; not maskable
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      nmi_old_r <= 1'b0;
      nmi_pend_o <= 1'b0;
    end else begin
      nmi_old_r <= nmi_lvl_r;
      if (nmi_lvl_r && !nmi_old_r) nmi_pend_o <= 1'b1;
      else if (enter_i && enter_id_i == '1) nmi_pend_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_enter_clears: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    enter_i && int'(enter_id_i) < N && !rise[enter_id_i] && !w_set[enter_id_i]
      |=> act_r[$past(enter_id_i)] && (type_r[$past(enter_id_i)] || !pend_r[$past(enter_id_i)]))
    else $error("entry did not mark active");
  a_level_pend: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    !type_r[2] && line_r[2] && !act_r[2] && !enter_v[2] |=> pend_r[2])
    else $error("level line did not pend");
  a_pulse_pend: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    type_r[4] && rise[4] |=> pend_r[4])
    else $error("pulse lost");
  a_level_clr: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    !type_r[2] && w_clr[2] && line_r[2] && !enter_v[2]
      |=> pend_r[2] == $past(pend_r[2]) || pend_r[2])
    else $error("clear took effect with line high");
  a_pulse_clr: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    type_r[4] && w_clr[4] && !rise[4] && !w_set[4] && !enter_v[4] && !ret_v[4]
      |=> !pend_r[4] && act_r[4] == $past(act_r[4]))
    else $error("pulse clear wrong");
  a_pulse_ret: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    type_r[4] && ret_v[4] && !enter_v[4] |=> !act_r[4])
    else $error("pulse return left active");
  a_sw_set: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    w_set[3] |=> pend_r[3])
    else $error("software set ignored");
  a_arb_win: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    best_v |=> req_valid_o && req_id_o == $past(best_id))
    else $error("request not presented");
  a_reset_clear: assert property (@(posedge sys_clk_i)
    sys_rst_i |=> pend_r == '0 && act_r == '0)
    else $error("reset left state");
  c_enter: cover property (@(posedge sys_clk_i) enter_i && req_valid_o);
  c_reentry: cover property (@(posedge sys_clk_i) ret_v[2] ##1 pend_r[2]);
  c_nmi: cover property (@(posedge sys_clk_i) nmi_pend_o);
endmodule // nested_vector_irq_ctrl

// *** prio_table.sv ***
`timescale 1ns/1ps
// Small memory for per-interrupt priority, registered read port
module prio_table #(
  parameter int DEPTH = 21,
  parameter int WIDTH = 3
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic wr_en_i,
  input wire logic [4:0] wr_idx_i,
  input wire logic [WIDTH-1:0] wr_data_i,
  input wire logic [4:0] rd_idx_i,
  output logic [WIDTH-1:0] rd_data_o,
  output logic [DEPTH*WIDTH-1:0] all_o
);
  logic [WIDTH-1:0] mem_r [DEPTH];

  initial begin
    if (DEPTH < 1 || DEPTH > 32) $error("prio_table depth out of range");
  end

  // ------------------------------------------------------------
  // Storage; cleared on reset so arbitration starts defined
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    for (int i = 0; i < DEPTH; i++) begin
      if (sys_rst_i) begin
        mem_r[i] <= '0;
      end else if (wr_en_i && wr_idx_i == 5'(i)) begin
        mem_r[i] <= wr_data_i;
      end
    end
  end

  // Registered read data
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      rd_data_o <= '0;
    end else if (int'(rd_idx_i) < DEPTH) begin
      rd_data_o <= mem_r[rd_idx_i];
    end else begin
      rd_data_o <= '0;
    end
  end

  // Flat view for the arbiter
  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      all_o[i*WIDTH +: WIDTH] = mem_r[i];
    end
  end
endmodule // prio_table

// *** tb.sv ***
`timescale 1ns/1ps
module tb;
  import irq_pkg::*;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic sys_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [NUM_IRQ-1:0] irq_line;
  logic nmi_line, enter, ret, req_valid, nmi_pend;
  logic [ID_W-1:0] enter_id, ret_id, req_id;
  logic [PRIO_W-1:0] req_group, req_sub;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic [DATA_W-1:0] rdata;
  logic wr = 1'b0;
  logic rd = 1'b0;
  int n_fail = 0;
  int n_compared = 0;

  // 25 ns period
  always #12.5 sys_clk_i = ~sys_clk_i;

  nested_vector_irq_ctrl u_dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .irq_line_i(irq_line), .nmi_line_i(nmi_line), .enter_i(enter), .enter_id_i(enter_id),
    .return_i(ret), .return_id_i(ret_id), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata), .req_valid_o(req_valid), .req_id_o(req_id),
    .req_group_o(req_group), .req_sub_o(req_sub), .nmi_pend_o(nmi_pend));
  irq_peer_model u_peer (.sys_clk_i(sys_clk_i), .irq_line_o(irq_line),
    .nmi_line_o(nmi_line), .enter_o(enter), .enter_id_o(enter_id), .return_o(ret),
    .return_id_o(ret_id));

  // ------------------------------------------------------------
  // Bus and compare helpers
  // ------------------------------------------------------------
  task automatic bus_wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk_i);
    wr <= 1'b0;
  endtask
  // Data stands only in the cycle after the strobe
  task automatic bus_rd(input logic [15:0] a, output logic [31:0] d);
    @(posedge sys_clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk_i);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_reg(input logic [15:0] a, input logic [31:0] exp);
    logic [31:0] d;
    bus_rd(a, d);
    chk(d, exp);
  endtask
  // Line sync 3-4 edges, then pending, then request: 8 is enough
  task automatic settle();
    repeat (8) @(posedge sys_clk_i);
    #1;
  endtask
  // Bounded wait for a given winner; a miss ends the run
  task automatic wait_req(input int id);
    int i;
    i = 0;
    #1;
    while (i < 16 && !(req_valid === 1'b1 && req_id === id[4:0])) begin
      @(posedge sys_clk_i);
      #1;
      i++;
    end
    n_compared++;
    if (i == 16) begin
      n_fail++;
      $display("BAD t=%0t no request for %0d", $time, id);
      finish_test();
    end
  endtask
  task automatic finish_test();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    chk_reg(OFF_PEND_SET, ZERO_WORD);
    chk_reg(OFF_ACTIVE, ZERO_WORD);
    chk(32'(req_valid), ZERO_WORD);
    chk_reg(16'h0000, ZERO_WORD);
    $display("reset test done");
  endtask
  // Software pending, trigger window, masking, reprioritising
  task automatic t_soft();
    bus_wr(OFF_PRIO_BASE + 16'h000C, 32'h0000_0080);
    bus_wr(OFF_PRIO_BASE + 16'h0014, 32'h0000_0020);
    bus_wr(OFF_EN_CLR, 32'h0000_0008);
    bus_wr(OFF_PEND_SET, 32'h0000_0008);
    settle();
    chk(32'(req_valid), ZERO_WORD);
    bus_wr(OFF_EN_SET, 32'h0000_0008);
    wait_req(3);
    bus_wr(OFF_SW_TRIG, 32'h0000_0005);
    wait_req(5);
    chk_reg(OFF_PEND_SET, 32'h0000_0028);
    bus_wr(OFF_PRIO_BASE + 16'h000C, 32'h0000_0000);
    wait_req(3);
    chk_reg(OFF_PRIO_BASE + 16'h0014, 32'h0000_0020);
    bus_wr(OFF_PEND_CLR, 32'h0000_0028);
    settle();
    chk_reg(OFF_PEND_SET, ZERO_WORD);
    chk(32'(req_valid), ZERO_WORD);
    $display("software pending test done");
  endtask
  // Equal priority: lowest number first; only 21 bits exist
  task automatic t_tie();
    bus_wr(OFF_PEND_SET, 32'h0010_0280);
    wait_req(7);
    bus_wr(OFF_PEND_CLR, 32'h0000_0080);
    wait_req(9);
    bus_wr(OFF_PEND_CLR, 32'h0000_0200);
    wait_req(20);
    bus_wr(OFF_PEND_SET, 32'hFFFF_FFFF);
    chk_reg(OFF_PEND_SET, 32'h001F_FFFF);
    bus_wr(OFF_PEND_CLR, 32'hFFFF_FFFF);
    $display("tie test done");
  endtask
  // Priority 5 with split 1 gives group 2, sub 1
  task automatic t_group();
    bus_wr(OFF_PRIO_BASE + 16'h0018, 32'h0000_00A0);
    bus_wr(OFF_GROUP, 32'h0000_0001);
    bus_wr(OFF_PEND_SET, 32'h0000_0040);
    wait_req(6);
    chk(32'(req_group), 32'h0000_0002);
    chk(32'(req_sub), 32'h0000_0001);
    bus_wr(OFF_GROUP, ZERO_WORD);
    bus_wr(OFF_PEND_CLR, 32'h0000_0040);
    $display("group test done");
  endtask
  task automatic t_level();
    u_peer.level_set(2, 1'b1);
    wait_req(2);
    chk_reg(OFF_PRESENT, 32'h0000_0004);
    u_peer.core_event(1'b0, 2);
    settle();
    chk_reg(OFF_ACTIVE, 32'h0000_0004);
    chk_reg(OFF_PEND_SET, ZERO_WORD);
    u_peer.core_event(1'b1, 2);
    wait_req(2);
    bus_wr(OFF_PEND_CLR, 32'h0000_0004);
    settle();
    chk_reg(OFF_PEND_SET, 32'h0000_0004);
    u_peer.core_event(1'b0, 2);
    u_peer.level_set(2, 1'b0);
    settle();
    u_peer.core_event(1'b1, 2);
    settle();
    chk_reg(OFF_ACTIVE, ZERO_WORD);
    chk_reg(OFF_PEND_SET, ZERO_WORD);
    $display("level test done");
  endtask
  task automatic t_pulse();
    bus_wr(OFF_TYPE, 32'h0000_0010);
    u_peer.pulse(4);
    wait_req(4);
    bus_wr(OFF_PEND_CLR, 32'h0000_0010);
    chk_reg(OFF_PEND_SET, ZERO_WORD);
    u_peer.pulse(4);
    wait_req(4);
    u_peer.core_event(1'b0, 4);
    u_peer.pulse(4);
    settle();
    chk_reg(OFF_PEND_SET, 32'h0000_0010);
    bus_wr(OFF_PEND_CLR, 32'h0000_0010);
    chk_reg(OFF_PEND_SET, ZERO_WORD);
    chk_reg(OFF_ACTIVE, 32'h0000_0010);
    u_peer.pulse(4);
    settle();
    u_peer.core_event(1'b1, 4);
    wait_req(4);
    chk_reg(OFF_ACTIVE, ZERO_WORD);
    u_peer.core_event(1'b0, 4);
    u_peer.core_event(1'b1, 4);
    settle();
    chk_reg(OFF_PEND_SET, ZERO_WORD);
    chk_reg(OFF_ACTIVE, ZERO_WORD);
    bus_wr(OFF_TYPE, ZERO_WORD);
    $display("pulse test done");
  endtask
  task automatic t_nmi();
    u_peer.pulse(31);
    settle();
    chk(32'(nmi_pend), 32'h0000_0001);
    u_peer.core_event(1'b0, 31);
    settle();
    chk(32'(nmi_pend), ZERO_WORD);
    $display("nmi test done");
  endtask

  // Main sequence
  initial begin
    repeat (6) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    t_reset();
    bus_wr(OFF_EN_SET, 32'h001F_FFFF);
    t_soft();
    t_tie();
    t_group();
    t_level();
    t_pulse();
    t_nmi();
    finish_test();
  end
endmodule // tb
